// ==== src/wrap_timer.sv ====
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "wrap_timer_params.svh"
module wrap_timer (
  input wire logic mclk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [3:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // counting sources
  input wire logic ext_count_input,
  input wire logic fixed_rate_clock,
  // low power and debug state from the core
  input wire logic stop_mode,
  input wire logic deep_stop_wake,
  input wire logic bdm_active,
  // overflow interrupt request
  output logic overflow_irq
);

  // registers
  logic [7:0] count_ff; // live count
  logic [7:0] nxt_count;
  logic [7:0] limit_ff; // wrap limit
  logic flag_ff; // overflow flag
  logic nxt_flag;
  logic irq_en_ff; // overflow interrupt enable
  logic halt_ff; // counter halt
  wrap_timer_pkg::source_sel_t src_ff; // source select
  logic [3:0] ps_ff; // prescale select
  logic [7:0] presc_ff; // prescaler chain
  logic armed_ff; // status read seen with flag set
  logic irq_ff;
  logic [31:0] rdata_ff;
  logic ready_ff;
  logic err_ff;
  // synchronisers and edge history
  logic ext_s1_ff;
  logic ext_s2_ff;
  logic ext_s3_ff;
  logic fix_s1_ff;
  logic fix_s2_ff;
  logic fix_s3_ff;

  // soft reset also covers the deepest stop wake
  wire srst = rst | deep_stop_wake;

  // apb decode
  wire acc = psel & penable & ready_ff; // completing transfer
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire sel_sc = paddr == `OFF_STATUS_CONTROL;
  wire sel_cc = paddr == `OFF_CLOCK_CONFIG;
  wire sel_cv = paddr == `OFF_COUNT_VALUE;
  wire sel_wl = paddr == `OFF_WRAP_LIMIT;
  wire mapped = sel_sc | sel_cc | sel_cv | sel_wl;
  wire wr_sc = wr & sel_sc;
  wire wr_wl = wr & sel_wl;
  wire rd_sc = rd & sel_sc;

  // counter reset by clear bit or any limit write
  wire cnt_clr = (wr_sc & pwdata[`SC_CLEAR_BIT]) | wr_wl;

  // edge detect on second and third stages only
  wire ext_rise = ext_s2_ff & ~ext_s3_ff;
  wire ext_fall = ~ext_s2_ff & ext_s3_ff;
  wire fix_rise = fix_s2_ff & ~fix_s3_ff;

  // source select: pin used for the two upper codes
  wire tick = source_tick(src_ff, ext_rise, ext_fall, fix_rise);

  // run unless halted, stopped or in debug; wait mode is not a gate
  wire run = ~halt_ff & ~stop_mode & ~bdm_active;

  // prescaler: step when low ps bits of chain are all ones
  wire [3:0] ps_eff = (ps_ff > `PS_MAX) ? `PS_MAX : ps_ff;
  // one bit past the mask, so that a divide by 256 still fits nine bits
  wire [8:0] ps_span = 9'h001 << ps_eff;
  wire [7:0] ps_mask = 8'(ps_span - 9'h001);
  wire step = run & tick & ((presc_ff & ps_mask) == ps_mask);

  // limit zero means run free up to the maximum
  wire [7:0] top = (limit_ff == `LIMIT_RESET) ? `COUNT_MAX : limit_ff;
  wire wrap_hit = count_ff == top;
  wire ovf_evt = step & wrap_hit & ~cnt_clr;

  // zero write clears flag only after the arming read
  wire flag_wr0 = wr_sc & armed_ff & ~pwdata[`SC_FLAG_BIT];

  // readback mux
  wire [7:0] sc_rd = {flag_ff, irq_en_ff, 1'b0, halt_ff, 4'h0};
  wire [7:0] cc_rd = {2'h0, src_ff, ps_ff};
  wire [7:0] rd_byte = sel_sc ? sc_rd :
                       sel_cc ? cc_rd :
                       sel_cv ? count_ff :
                       sel_wl ? limit_ff : 8'h00;

  // picks the tick for the chosen source
  function automatic logic source_tick(
    input wrap_timer_pkg::source_sel_t s,
    input logic er,
    input logic ef,
    input logic fr
  );
    case (s)
      wrap_timer_pkg::SRC_BUS: source_tick = 1'b1;
      wrap_timer_pkg::SRC_FIXED: source_tick = fr;
      wrap_timer_pkg::SRC_EXT_FALL: source_tick = ef;
      wrap_timer_pkg::SRC_EXT_RISE: source_tick = er;
      default: source_tick = 1'b1;
    endcase
  endfunction

  // next count: clear first, then wrap or increment
  always_comb begin
    if (cnt_clr) begin
      nxt_count = `COUNT_RESET;
    end else if (step && wrap_hit) begin
      nxt_count = `COUNT_RESET;
    end else if (step) begin
      nxt_count = count_ff + 8'h01;
    end else begin
      nxt_count = count_ff;
    end
  end

  // next flag: a set wins over a zero write; ovf_evt already excludes a counter clear
  always_comb begin
    if (ovf_evt) begin
      nxt_flag = 1'b1;
    end else if (cnt_clr || flag_wr0) begin
      nxt_flag = 1'b0;
    end else begin
      nxt_flag = flag_ff;
    end
  end

  // two-stage synchronisers plus edge history
  always_ff @(posedge mclk) begin
    if (srst) begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_s3_ff <= 1'b0;
      fix_s1_ff <= 1'b0;
      fix_s2_ff <= 1'b0;
      fix_s3_ff <= 1'b0;
    end else begin
      ext_s1_ff <= ext_count_input;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
      fix_s1_ff <= fixed_rate_clock;
      fix_s2_ff <= fix_s1_ff;
      fix_s3_ff <= fix_s2_ff;
    end
  end

  // counter and flag
  always_ff @(posedge mclk) begin
    if (srst) begin
      count_ff <= `COUNT_RESET;
      flag_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      flag_ff <= nxt_flag;
    end
  end

  // prescaler chain advances on every running source tick
  always_ff @(posedge mclk) begin
    if (srst || cnt_clr) begin
      presc_ff <= 8'h00;
    end else if (run && tick) begin
      presc_ff <= presc_ff + 8'h01;
    end
  end

  // control registers; count register writes are dropped
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_en_ff <= 1'b0;
      halt_ff <= `HALT_RESET;
      src_ff <= wrap_timer_pkg::SRC_BUS;
      ps_ff <= `PS_RESET;
      limit_ff <= `LIMIT_RESET;
    end else begin
      if (wr_sc) begin
        irq_en_ff <= pwdata[`SC_IRQ_EN_BIT];
        halt_ff <= pwdata[`SC_HALT_BIT];
      end
      if (wr & sel_cc) begin
        src_ff <= wrap_timer_pkg::source_sel_t'(pwdata[`CC_SRC_HI:`CC_SRC_LO]);
        ps_ff <= pwdata[`CC_PS_HI:`CC_PS_LO];
      end
      if (wr_wl) begin
        limit_ff <= pwdata[7:0];
      end
    end
  end

  // arming read for the flag clear sequence
  always_ff @(posedge mclk) begin
    if (srst || wr_sc) begin
      armed_ff <= 1'b0;
    end else if (rd_sc && flag_ff) begin
      armed_ff <= 1'b1;
    end
  end

  // interrupt level from flag and enable
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= flag_ff & irq_en_ff;
    end
  end

  // apb answer: one wait state, data and error with pready
  always_ff @(posedge mclk) begin
    if (srst) begin
      ready_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      err_ff <= 1'b0;
    end else begin
      ready_ff <= psel & penable & ~ready_ff;
      if (psel && penable && !ready_ff) begin
        rdata_ff <= pwrite ? 32'h0000_0000 : {24'h000000, rd_byte};
        err_ff <= ~mapped;
      end else begin
        rdata_ff <= 32'h0000_0000;
        err_ff <= 1'b0;
      end
    end
  end

  assign prdata = rdata_ff;
  assign pready = ready_ff;
  assign pslverr = err_ff;
  assign overflow_irq = irq_ff;

  // checks
  property p_incr;
    @(posedge mclk) disable iff (srst)
    (step && !wrap_hit && !cnt_clr) |=> count_ff == $past(count_ff) + 8'h01;
  endproperty
  a_incr: assert property (p_incr) else $error("count did not step");

  property p_wrap;
    @(posedge mclk) disable iff (srst)
    ovf_evt |=> (count_ff == 8'h00) && flag_ff;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap or flag wrong");

  property p_flag_set;
    @(posedge mclk) disable iff (srst)
    $rose(flag_ff) |-> $past(step) && $past(wrap_hit);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag set w/o wrap");

  property p_halt;
    @(posedge mclk) disable iff (srst)
    (halt_ff && !cnt_clr) |=> $stable(count_ff);
  endproperty
  a_halt: assert property (p_halt) else $error("count moved in halt");

  property p_stop;
    @(posedge mclk) disable iff (srst)
    (stop_mode && !cnt_clr) [*2] |=> $stable(count_ff) && $stable(presc_ff);
  endproperty
  a_stop: assert property (p_stop) else $error("activity in stop");

  property p_bdm;
    @(posedge mclk) disable iff (srst)
    (bdm_active && !cnt_clr) |=> $stable(count_ff);
  endproperty
  a_bdm: assert property (p_bdm) else $error("count moved in debug");

  property p_clear;
    @(posedge mclk) disable iff (srst)
    cnt_clr |=> (count_ff == 8'h00) && !flag_ff;
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");

  property p_flag_wr0;
    @(posedge mclk) disable iff (srst)
    (flag_wr0 && !ovf_evt) |=> !flag_ff;
  endproperty
  a_flag_wr0: assert property (p_flag_wr0) else $error("flag not cleared");

  property p_irq;
    @(posedge mclk) disable iff (srst)
    (flag_ff && irq_en_ff) ##1 (flag_ff && irq_en_ff) |=> overflow_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not held");

  property p_irq_cause;
    @(posedge mclk) disable iff (srst)
    overflow_irq |-> $past(flag_ff) && $past(irq_en_ff);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq w/o cause");

  property p_ext_edge;
    @(posedge mclk) disable iff (srst)
    (src_ff == wrap_timer_pkg::SRC_EXT_RISE && tick) |-> $past(ext_s1_ff) && !$past(ext_s2_ff);
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("pin edge wrong");

  property p_sc_zero;
    @(posedge mclk) disable iff (srst)
    (psel && penable && !ready_ff && !pwrite && sel_sc) |=> prdata[5:0] == {1'b0, halt_ff, 4'h0};
  endproperty
  a_sc_zero: assert property (p_sc_zero) else $error("status low bits");

  property p_bus_src;
    @(posedge mclk) disable iff (srst)
    (src_ff == wrap_timer_pkg::SRC_BUS && run && ps_ff == `PS_RESET && !cnt_clr && !wrap_hit)
      |=> count_ff == $past(count_ff) + 8'h01;
  endproperty
  a_bus_src: assert property (p_bus_src) else $error("bus source did not step");

  property p_cnt_ro;
    @(posedge mclk) disable iff (srst)
    (!step && !cnt_clr) |=> $stable(count_ff);
  endproperty
  a_cnt_ro: assert property (p_cnt_ro) else $error("count moved without a step");

  property p_irq_off;
    @(posedge mclk) disable iff (srst)
    (!flag_ff || !irq_en_ff) |=> !overflow_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq without flag and enable");

  property p_flag_hold;
    @(posedge mclk) disable iff (srst)
    (flag_ff && !cnt_clr && !flag_wr0) |=> flag_ff;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped by itself");

  property p_wr_wl;
    @(posedge mclk) disable iff (srst)
    wr_wl |=> (limit_ff == $past(pwdata[7:0])) && (count_ff == `COUNT_RESET);
  endproperty
  a_wr_wl: assert property (p_wr_wl) else $error("limit write not taken");

endmodule // wrap_timer
`default_nettype wire

// ==== src/wrap_timer_params.svh ====
`ifndef WRAP_TIMER_PARAMS_SVH
`define WRAP_TIMER_PARAMS_SVH
// register byte addresses on the apb word grid
`define OFF_STATUS_CONTROL 4'h0
`define OFF_CLOCK_CONFIG 4'h4
`define OFF_COUNT_VALUE 4'h8
`define OFF_WRAP_LIMIT 4'hC
// status and control field positions
`define SC_FLAG_BIT 7
`define SC_IRQ_EN_BIT 6
`define SC_CLEAR_BIT 5
`define SC_HALT_BIT 4
// clock configuration field positions
`define CC_SRC_HI 5
`define CC_SRC_LO 4
`define CC_PS_HI 3
`define CC_PS_LO 0
// reset values and constants
`define COUNT_RESET 8'h00
`define LIMIT_RESET 8'h00
`define COUNT_MAX 8'hFF
`define PS_RESET 4'h0
`define PS_MAX 4'h8
`define HALT_RESET 1'b1
`endif

// ==== src/wrap_timer_pkg.sv ====
package wrap_timer_pkg;
  // prescaler input choice, declaration order gives codes 00..11
  typedef enum logic [1:0] {
    SRC_BUS,
    SRC_FIXED,
    SRC_EXT_FALL,
    SRC_EXT_RISE
  } source_sel_t;
  // one eight-bit register value
  typedef logic [7:0] reg8_t;
endpackage

// ==== verif/wrap_timer_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module wrap_timer_tb_top;
  logic mclk = 1'b0; // bus clock, 4 ns
  logic rst = 1'b1; // synchronous reset
  logic psel = 1'b0; // apb select
  logic penable = 1'b0; // apb access phase
  logic pwrite = 1'b0; // apb direction
  logic [3:0] paddr = 4'h0; // apb byte address
  logic [31:0] pwdata = 32'h0; // apb write data
  logic [31:0] prdata; // apb read data
  logic pready; // apb answer
  logic pslverr; // apb error
  logic ext_count_input = 1'b0; // external count pin
  logic fixed_rate_clock = 1'b0; // fixed-rate source
  logic stop_mode = 1'b0; // stop mode level
  logic deep_stop_wake = 1'b0; // deepest stop wake
  logic bdm_active = 1'b0; // debug mode level
  logic overflow_irq; // interrupt request
  logic last_err; // pslverr of the last transfer
  int num_errors = 0; // mismatches seen
  int checks = 0; // comparisons made
  int cyc = 0; // cycles for the hang guard
  always #2 mclk = ~mclk;
  wrap_timer dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_count_input(ext_count_input), .fixed_rate_clock(fixed_rate_clock),
    .stop_mode(stop_mode), .deep_stop_wake(deep_stop_wake), .bdm_active(bdm_active),
    .overflow_irq(overflow_irq));
  // verdict and end of run
  task automatic end_of_test();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // hang guard, well above the ~9000 cycles the sequence needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      end_of_test();
    end
  end
  // compare one value with case equality
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // register write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    apb(1'b1, a, {24'h0, d}, q);
  endtask
  // register read and compare
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(nm, {24'h0, e}, q);
  endtask
  // n source pulses at an eighth of the bus rate, then settle
  task automatic pulses(input int n, input logic fx);
    repeat (n) begin
      @(posedge mclk);
      if (fx) fixed_rate_clock <= 1'b1;
      else ext_count_input <= 1'b1;
      repeat (4) @(posedge mclk);
      if (fx) fixed_rate_clock <= 1'b0;
      else ext_count_input <= 1'b0;
      repeat (3) @(posedge mclk);
    end
    repeat (6) @(posedge mclk);
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rd(4'h0, 8'h10, "status");
    rd(4'h4, 8'h00, "config");
    rd(4'h8, 8'h00, "count");
    rd(4'hC, 8'h00, "limit");
    // unmapped place and read-only count
    wr(4'h2, 8'hFF);
    chk("pslverr", 32'h1, {31'h0, last_err});
    wr(4'h8, 8'h55);
    rd(4'h8, 8'h00, "count_ro");
    // external pin, rising then falling edge
    wr(4'h4, 8'h30);
    wr(4'h0, 8'h20);
    pulses(5, 1'b0);
    rd(4'h8, 8'h05, "ext_rise");
    wr(4'h4, 8'h20);
    wr(4'h0, 8'h20);
    pulses(3, 1'b0);
    rd(4'h8, 8'h03, "ext_fall");
    // every prescale factor: 2**p ticks give one step
    for (int p = 0; p < 9; p++) begin
      wr(4'h4, 8'h30 | 8'(p));
      wr(4'h0, 8'h20);
      pulses(1 << p, 1'b0);
      rd(4'h8, 8'h01, "prescale");
    end
    // codes above eight divide by 256 as well
    wr(4'h4, 8'h3F);
    wr(4'h0, 8'h20);
    pulses(255, 1'b0);
    rd(4'h8, 8'h00, "ps_clamp_lo");
    pulses(1, 1'b0);
    rd(4'h8, 8'h01, "ps_clamp");
    // fixed-rate source
    wr(4'h4, 8'h10);
    wr(4'h0, 8'h20);
    pulses(4, 1'b1);
    rd(4'h8, 8'h04, "fixed");
    // stop freezes, leaving stop resumes
    wr(4'h4, 8'h30);
    wr(4'h0, 8'h20);
    stop_mode <= 1'b1;
    pulses(3, 1'b0);
    stop_mode <= 1'b0;
    rd(4'h8, 8'h00, "stop");
    pulses(2, 1'b0);
    rd(4'h8, 8'h02, "stop_exit");
    // debug suspends counting
    bdm_active <= 1'b1;
    pulses(3, 1'b0);
    bdm_active <= 1'b0;
    rd(4'h8, 8'h02, "debug");
    // halt freezes, release resumes
    wr(4'h0, 8'h10);
    pulses(2, 1'b0);
    rd(4'h8, 8'h02, "halt");
    wr(4'h0, 8'h00);
    pulses(1, 1'b0);
    rd(4'h8, 8'h03, "resume");
    // modulo wrap and overflow flag
    wr(4'hC, 8'h03);
    rd(4'h8, 8'h00, "limit_clr");
    pulses(3, 1'b0);
    rd(4'h0, 8'h00, "no_flag");
    pulses(1, 1'b0);
    rd(4'h8, 8'h00, "wrap");
    rd(4'h0, 8'h80, "flag");
    wr(4'h0, 8'h00);
    rd(4'h0, 8'h00, "flag_clr");
    wr(4'h0, 8'h40);
    pulses(4, 1'b0);
    chk("irq", 32'h1, {31'h0, overflow_irq});
    rd(4'h0, 8'hC0, "status_irq");
    wr(4'h0, 8'h60);
    rd(4'h8, 8'h00, "clear_bit");
    chk("irq_off", 32'h0, {31'h0, overflow_irq});
    rd(4'h0, 8'h40, "flag_gone");
    // a zero written without a prior read of the set flag does nothing
    pulses(4, 1'b0);
    wr(4'h0, 8'h40);
    rd(4'h0, 8'hC0, "no_arm");
    wr(4'hC, 8'h00);
    rd(4'h0, 8'h40, "limit_wr");
    // free run wraps after 256 steps
    pulses(256, 1'b0);
    rd(4'h0, 8'hC0, "free_run");
    // deepest stop wake restores reset state
    @(posedge mclk);
    deep_stop_wake <= 1'b1;
    @(posedge mclk);
    deep_stop_wake <= 1'b0;
    rd(4'h0, 8'h10, "wake_status");
    rd(4'h4, 8'h00, "wake_config");
    chk("wake_irq", 32'h0, {31'h0, overflow_irq});
    end_of_test();
  end
endmodule // wrap_timer_tb_top
`default_nettype wire
